/* logic/dbr_pkg.sv */
// Purpose: shared constants for the debug breakpoint register bank
// Assumes: register numbers 0..7 as carried by the move instruction
// Notes:   status view is rebuilt on read from a few stored bits
package dbr_pkg;
  localparam int unsigned NUM_BP = 4;

  // register numbers seen on a move
  localparam logic [2:0] REG_BP_LAST    = 3'h3;
  localparam logic [2:0] REG_ALIAS_STAT = 3'h4;
  localparam logic [2:0] REG_ALIAS_CTRL = 3'h5;
  localparam logic [2:0] REG_STATUS     = 3'h6;
  localparam logic [2:0] REG_CONTROL    = 3'h7;

  // status layout
  localparam int unsigned STAT_ACCESS_BIT = 13;
  localparam int unsigned STAT_STEP_BIT   = 14;
  localparam int unsigned STAT_TASK_BIT   = 15;
  localparam logic [31:0] STAT_FIXED_ONES = 32'hffff0ff0;

  // control layout
  localparam int unsigned CTRL_TRAP_BIT   = 13;
  localparam int unsigned CTRL_FIELD_BASE = 16;
  localparam int unsigned CTRL_FIELD_STEP = 4;
  localparam logic [31:0] CTRL_RAZ_MASK   = 32'h0000d800;
  localparam logic [31:0] CTRL_RA1_MASK   = 32'h00000400;
  localparam logic [31:0] CTRL_LOCAL_MASK = 32'h00000055;
  localparam logic [31:0] CTRL_RESET      = 32'h00000400;

  // privilege
  localparam logic [1:0] CPL_TOP = 2'h0;

  // match type field
  localparam logic [1:0] TYPE_EXEC  = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_IO    = 2'h2;
  localparam logic [1:0] TYPE_RW    = 2'h3;

  // match length field
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_2 = 2'h1;
  localparam logic [1:0] LEN_8 = 2'h2;
  localparam logic [1:0] LEN_4 = 2'h3;

  // kind of access presented for comparison
  localparam logic [1:0] KIND_EXEC  = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_IO    = 2'h2;
  localparam logic [1:0] KIND_READ  = 2'h3;
endpackage

/* logic/dbr_match.sv */
// Purpose: one address breakpoint comparator
// Assumes: address aligned to its length by software
// Notes:   purely combinational, no state
module dbr_match (
  input  wire logic [63:0] bpAddr,
  input  wire logic        enableLocal,
  input  wire logic        enableGlobal,
  input  wire logic [1:0]  typeField,
  input  wire logic [1:0]  lenField,
  input  wire logic        accValid,
  input  wire logic [63:0] accAddr,
  input  wire logic [1:0]  accKind,
  input  wire logic        mode64,
  input  wire logic        debugExt,
  output logic             hit
);
  logic [63:0] lowMask;
  logic        kindOk;

  always_comb begin
    // length masks low address bits out of the compare
    case (lenField)
      dbr_pkg::LEN_2: lowMask = 64'h1;
      dbr_pkg::LEN_4: lowMask = 64'h3;
      // 8-byte range exists only in long mode
      dbr_pkg::LEN_8: lowMask = mode64 ? 64'h7 : 64'h0;
      default:        lowMask = 64'h0;
    endcase
    case (typeField)
      dbr_pkg::TYPE_EXEC:  kindOk = accKind == dbr_pkg::KIND_EXEC;
      dbr_pkg::TYPE_WRITE: kindOk = accKind == dbr_pkg::KIND_WRITE;
      // undefined without debug extensions: never match
      dbr_pkg::TYPE_IO:    kindOk = debugExt &&
                                    accKind == dbr_pkg::KIND_IO;
      default:             kindOk = accKind == dbr_pkg::KIND_WRITE ||
                                    accKind == dbr_pkg::KIND_READ;
    endcase
    hit = accValid && kindOk && (enableLocal || enableGlobal) &&
          ((bpAddr & ~lowMask) == (accAddr & ~lowMask));
  end
endmodule

/* logic/dbr_bank.sv */
// Purpose: debug breakpoint register bank with exception capture
// Assumes: moves, accesses and events arrive on ref_clk, one per cycle
// Notes:   faults and the debug exception are one-cycle pulses
module dbr_bank (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        movValid,
  input  wire logic        movWrite,
  input  wire logic [2:0]  movRegNum,
  input  wire logic [63:0] movWdata,
  input  wire logic [1:0]  currentPrivilegeLevel,
  input  wire logic        longMode64,
  input  wire logic        debugExtensionsBit,
  input  wire logic        accessValid,
  input  wire logic [63:0] accessAddr,
  input  wire logic [1:0]  accessKind,
  input  wire logic        singleStepFlag,
  input  wire logic        taskSwitch,
  input  wire logic        taskTrapBit,
  input  wire logic        handlerEntry,
  output logic             movDone,
  output logic [63:0]      movRdata,
  output logic             protectionFault,
  output logic             invalidOpcodeFault,
  output logic             debugException
);
  typedef struct packed {
    logic [3:0][63:0] bpAddr;
    logic [31:0]      ctrl;
    logic [3:0]       hitFlags;
    logic             accessHit;
    logic             stepHit;
    logic             taskHit;
    logic [63:0]      rdata;
    logic             done;
    logic             gpf;
    logic             ud;
    logic             dbx;
  } dbr_state_t;

  dbr_state_t st_r;
  dbr_state_t st_nxt;

  logic [3:0]  hitVec;
  logic [2:0]  effReg;
  logic        privOk;
  logic        udTrap;
  logic        gdTrap;
  logic        gpUpper;
  logic        commit;
  logic        stepEvent;
  logic        taskEvent;
  logic        bpEvent;
  logic [63:0] wval;
  logic [63:0] readVal;
  logic [31:0] statusLow;

  // fold the reserved numbers onto status and control
  function automatic logic [2:0] map_reg(input logic [2:0] num);
    logic [2:0] r;
    r = num;
    if (num == dbr_pkg::REG_ALIAS_STAT) begin
      r = dbr_pkg::REG_STATUS;
    end else if (num == dbr_pkg::REG_ALIAS_CTRL) begin
      r = dbr_pkg::REG_CONTROL;
    end
    return r;
  endfunction

  function automatic logic is_alias(input logic [2:0] num);
    return num == dbr_pkg::REG_ALIAS_STAT ||
           num == dbr_pkg::REG_ALIAS_CTRL;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < dbr_pkg::NUM_BP; gi++) begin : g_bp
      dbr_match u_match (
        .bpAddr       (st_r.bpAddr[gi]),
        .enableLocal  (st_r.ctrl[2*gi]),
        .enableGlobal (st_r.ctrl[2*gi+1]),
        .typeField    (st_r.ctrl[dbr_pkg::CTRL_FIELD_BASE +
                                 dbr_pkg::CTRL_FIELD_STEP*gi +: 2]),
        .lenField     (st_r.ctrl[dbr_pkg::CTRL_FIELD_BASE + 2 +
                                 dbr_pkg::CTRL_FIELD_STEP*gi +: 2]),
        .accValid     (accessValid),
        .accAddr      (accessAddr),
        .accKind      (accessKind),
        .mode64       (longMode64),
        .debugExt     (debugExtensionsBit),
        .hit          (hitVec[gi])
      );
    end
  endgenerate

  always_comb begin
    effReg    = map_reg(movRegNum);
    privOk    = currentPrivilegeLevel == dbr_pkg::CPL_TOP;
    udTrap    = is_alias(movRegNum) && debugExtensionsBit;
    gdTrap    = st_r.ctrl[dbr_pkg::CTRL_TRAP_BIT];
    // upper half of status and control must be zero in 64-bit mode
    gpUpper   = movWrite && longMode64 && (|movWdata[63:32]) &&
                (effReg == dbr_pkg::REG_STATUS ||
                 effReg == dbr_pkg::REG_CONTROL);
    commit    = movValid && privOk && !udTrap && !gdTrap && !gpUpper;
    stepEvent = singleStepFlag;
    taskEvent = taskSwitch && taskTrapBit;
    bpEvent   = |hitVec;
    // no operand-size input: width follows the mode alone
    wval      = longMode64 ? movWdata
                           : {32'h0, movWdata[31:0]};
    statusLow = dbr_pkg::STAT_FIXED_ONES;
    statusLow[3:0] = st_r.hitFlags;
    statusLow[dbr_pkg::STAT_ACCESS_BIT] = st_r.accessHit;
    statusLow[dbr_pkg::STAT_STEP_BIT]   = st_r.stepHit;
    statusLow[dbr_pkg::STAT_TASK_BIT]   = st_r.taskHit;
    case (effReg)
      dbr_pkg::REG_STATUS:  readVal = {32'h0, statusLow};
      dbr_pkg::REG_CONTROL: readVal = {32'h0, st_r.ctrl};
      default:              readVal = st_r.bpAddr[effReg[1:0]];
    endcase
    if (!longMode64) begin
      readVal[63:32] = 32'h0;
    end
  end

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    st_nxt.gpf  = 1'b0;
    st_nxt.ud   = 1'b0;
    st_nxt.dbx  = 1'b0;
    if (handlerEntry) begin
      st_nxt.ctrl[dbr_pkg::CTRL_TRAP_BIT] = 1'b0;
    end
    if (taskSwitch) begin
      // only the per-task enables die with the task
      st_nxt.ctrl = st_nxt.ctrl & ~dbr_pkg::CTRL_LOCAL_MASK;
    end
    if (movValid) begin
      if (!privOk) begin
        st_nxt.gpf = 1'b1;
      end else if (udTrap) begin
        st_nxt.ud = 1'b1;
      end else if (gdTrap) begin
        // trap is taken before the move, so only the access cause and hit flags are stored
        st_nxt.dbx       = 1'b1;
        st_nxt.accessHit = 1'b1;
        st_nxt.hitFlags  = hitVec;
      end else if (gpUpper) begin
        st_nxt.gpf = 1'b1;
      end else begin
        st_nxt.done = 1'b1;
        if (movWrite) begin
          case (effReg)
            dbr_pkg::REG_STATUS: begin
              st_nxt.hitFlags  = wval[3:0];
              st_nxt.accessHit = wval[dbr_pkg::STAT_ACCESS_BIT];
              st_nxt.stepHit   = wval[dbr_pkg::STAT_STEP_BIT];
              st_nxt.taskHit   = wval[dbr_pkg::STAT_TASK_BIT];
            end
            dbr_pkg::REG_CONTROL: begin
              st_nxt.ctrl = (wval[31:0] & ~dbr_pkg::CTRL_RAZ_MASK) |
                            dbr_pkg::CTRL_RA1_MASK;
            end
            default: begin
              st_nxt.bpAddr[effReg[1:0]] = wval;
            end
          endcase
        end else begin
          st_nxt.rdata = readVal;
        end
      end
    end
    // events come after the move so a same-cycle status write
    // cannot wipe a freshly detected cause
    if (bpEvent || stepEvent || taskEvent) begin
      st_nxt.dbx      = 1'b1;
      st_nxt.hitFlags = hitVec;
      if (stepEvent) begin
        st_nxt.stepHit = 1'b1;
      end
      if (taskEvent) begin
        st_nxt.taskHit = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r      <= '0;
      st_r.ctrl <= dbr_pkg::CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign movDone            = st_r.done;
  assign movRdata           = st_r.rdata;
  assign protectionFault    = st_r.gpf;
  assign invalidOpcodeFault = st_r.ud;
  assign debugException     = st_r.dbx;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence topMove;
    movValid && privOk;
  endsequence

  sequence trapMove;
    topMove ##0 !udTrap && gdTrap;
  endsequence

  sequence cleanMove;
    topMove ##0 !udTrap && !gdTrap && !gpUpper;
  endsequence

  priv_fault_a: assert property (
    movValid && !privOk |=> protectionFault && !movDone)
    else $error("move below privilege zero not faulted");

  alias_ud_a: assert property (
    topMove ##0 is_alias(movRegNum) && debugExtensionsBit
    |=> invalidOpcodeFault && !movDone && !protectionFault)
    else $error("reserved number not refused");

  alias_map_a: assert property (
    cleanMove ##0 !movWrite && movRegNum == dbr_pkg::REG_ALIAS_CTRL
    |=> movRdata[31:0] == $past(st_r.ctrl))
    else $error("alias does not read control");

  alias_stat_a: assert property (
    cleanMove ##0 !movWrite && movRegNum == dbr_pkg::REG_ALIAS_STAT
    |=> movRdata[31:0] == $past(statusLow))
    else $error("alias does not read status");

  low_half_a: assert property (
    cleanMove ##0 !movWrite && !longMode64
    |=> movDone && movRdata[63:32] == 32'h0)
    else $error("upper half leaked outside 64-bit mode");

  full_width_a: assert property (
    cleanMove ##0 movWrite && longMode64 &&
    movRegNum <= dbr_pkg::REG_BP_LAST
    |=> st_r.bpAddr[$past(movRegNum[1:0])] == $past(movWdata))
    else $error("breakpoint address not stored in full");

  access_trap_a: assert property (
    trapMove |=> debugException && st_r.accessHit && !movDone)
    else $error("trapped access missed");

  trap_clear_a: assert property (
    handlerEntry && !movValid |=> !st_r.ctrl[dbr_pkg::CTRL_TRAP_BIT])
    else $error("trap enable kept on handler entry");

  status_fixed_a: assert property (
    cleanMove ##0 !movWrite && effReg == dbr_pkg::REG_STATUS
    |=> movRdata[31:16] == 16'hffff && movRdata[12:4] == 9'h0ff)
    else $error("status reserved bits wrong");

  // task switch and handler entry may touch low control bits meanwhile
  upper_fault_a: assert property (
    topMove ##0 !udTrap && !gdTrap && gpUpper
    |=> protectionFault && !movDone && $stable(st_r.ctrl[31:16]) &&
    $stable(st_r.ctrl[12:8]))
    else $error("nonzero upper write accepted");

  sticky_hit_a: assert property (
    st_r.accessHit && !(commit && movWrite &&
    effReg == dbr_pkg::REG_STATUS) |=> st_r.accessHit)
    else $error("access hit cleared by hardware");

  step_hit_a: assert property (
    singleStepFlag |=> debugException && st_r.stepHit)
    else $error("single step not recorded");

  task_hit_a: assert property (
    taskSwitch && taskTrapBit |=> debugException && st_r.taskHit &&
    ((st_r.ctrl & dbr_pkg::CTRL_LOCAL_MASK) == 32'h0 || $past(movValid)))
    else $error("task switch not handled");

  global_keep_a: assert property (
    taskSwitch && !movValid && !handlerEntry
    |=> (st_r.ctrl | dbr_pkg::CTRL_LOCAL_MASK) ==
        ($past(st_r.ctrl) | dbr_pkg::CTRL_LOCAL_MASK))
    else $error("task switch touched global enables");

  hit_rewrite_a: assert property (
    accessValid && |hitVec |=> st_r.hitFlags == $past(hitVec) &&
    debugException)
    else $error("hit flags not rewritten");

  ctrl_fixed_a: assert property (
    (st_r.ctrl & dbr_pkg::CTRL_RAZ_MASK) == 32'h0 &&
    (st_r.ctrl & dbr_pkg::CTRL_RA1_MASK) == dbr_pkg::CTRL_RA1_MASK)
    else $error("control reserved bits wrong");
endmodule

/* testbench/testbench.sv */
// Purpose: self-checking bench for the debug breakpoint register bank
// Assumes: answers come one cycle after the move or event is taken
// Notes:   a reference model in the bench tracks control, status, addresses
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk;
  logic        reset_n;
  logic        movValid;
  logic        movWrite;
  logic [2:0]  movRegNum;
  logic [63:0] movWdata;
  logic [1:0]  currentPrivilegeLevel;
  logic        longMode64;
  logic        debugExtensionsBit;
  logic        accessValid;
  logic [63:0] accessAddr;
  logic [1:0]  accessKind;
  logic        singleStepFlag;
  logic        taskSwitch;
  logic        taskTrapBit;
  logic        handlerEntry;
  logic        movDone;
  logic [63:0] movRdata;
  logic        protectionFault;
  logic        invalidOpcodeFault;
  logic        debugException;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [31:0] seed = 32'hb40f;
  logic [31:0] mCtrl;
  logic [3:0]  mHit;
  logic [2:0]  mSt;
  logic [63:0] mBp [4];
  logic [63:0] d;
  localparam logic [63:0] ALL   = '1;
  localparam logic [63:0] NOHIT = ~64'hf;

  dbr_bank dbr_bank_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .movValid(movValid),
    .movWrite(movWrite), .movRegNum(movRegNum), .movWdata(movWdata),
    .currentPrivilegeLevel(currentPrivilegeLevel),
    .longMode64(longMode64), .debugExtensionsBit(debugExtensionsBit),
    .accessValid(accessValid), .accessAddr(accessAddr),
    .accessKind(accessKind), .singleStepFlag(singleStepFlag),
    .taskSwitch(taskSwitch), .taskTrapBit(taskTrapBit),
    .handlerEntry(handlerEntry), .movDone(movDone), .movRdata(movRdata),
    .protectionFault(protectionFault),
    .invalidOpcodeFault(invalidOpcodeFault),
    .debugException(debugException));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [63:0] rnd64();
    logic [63:0] r;
    for (int i = 0; i < 2; i++) begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      r = {r[31:0], seed};
    end
    return r;
  endfunction

  function automatic logic [63:0] st();
    return {32'h0, 16'hffff, mSt, 1'b0, 8'hff, mHit};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // c: 0 done, 1 protection fault, 2 invalid opcode, 3 debug exception
  task automatic mv(input int w, input int n, input logic [63:0] dt,
                    input int c, input logic [63:0] e, input logic [63:0] m);
    @(posedge ref_clk);
    movValid  <= 1'b1;
    movWrite  <= w[0];
    movRegNum <= n[2:0];
    movWdata  <= dt;
    @(posedge ref_clk);
    movValid <= 1'b0;
    movWdata <= ~dt;
    #1;
    chk({60'h0, debugException, invalidOpcodeFault, protectionFault, movDone},
        64'h1 << c);
    if (w == 0 && c == 0) chk(movRdata & m, e & m);
  endtask

  // f: {trap bit, task switch, single step, access valid}
  task automatic ev(input logic [63:0] a, input int k,
                    input logic [3:0] f, input logic x);
    @(posedge ref_clk);
    accessValid    <= f[0];
    accessAddr     <= a;
    accessKind     <= k[1:0];
    singleStepFlag <= f[1];
    taskSwitch     <= f[2];
    taskTrapBit    <= f[3];
    @(posedge ref_clk);
    accessValid    <= 1'b0;
    accessAddr     <= ~a;
    singleStepFlag <= 1'b0;
    taskSwitch     <= 1'b0;
    taskTrapBit    <= ~f[3];
    #1;
    chk({63'h0, debugException}, {63'h0, x});
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    {movValid, movWrite, movRegNum, movWdata} <= '0;
    {currentPrivilegeLevel, longMode64, debugExtensionsBit} <= '0;
    {accessValid, accessAddr, accessKind, singleStepFlag} <= '0;
    {taskSwitch, taskTrapBit, handlerEntry} <= '0;
    reset_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    mCtrl = 32'h400;
    mHit = 4'h0;
    mSt = 3'h0;
    mv(0, 7, 0, 0, {32'h0, mCtrl}, ALL);
    mv(0, 6, 0, 0, st(), ALL);
    longMode64 <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      mBp[i] = rnd64();
      mv(1, i[2:0], mBp[i], 0, 0, 0);
    end
    for (int i = 0; i < 4; i++) mv(0, i[2:0], 0, 0, mBp[i], ALL);
    longMode64 <= 1'b0;
    mv(0, 0, 0, 0, {32'h0, mBp[0][31:0]}, ALL);
    d = rnd64();
    mv(1, 3, d, 0, 0, 0);
    mv(0, 3, 0, 0, {32'h0, d[31:0]}, ALL);
    currentPrivilegeLevel <= 2'h3;
    mv(1, 0, rnd64(), 1, 0, 0);
    mv(0, 7, 0, 1, 0, 0);
    currentPrivilegeLevel <= 2'h0;
    mv(0, 0, 0, 0, {32'h0, mBp[0][31:0]}, ALL);
    mv(0, 4, 0, 0, st(), ALL);
    mv(0, 5, 0, 0, {32'h0, mCtrl}, ALL);
    debugExtensionsBit <= 1'b1;
    mv(0, 4, 0, 2, 0, 0);
    mv(1, 5, 64'h400, 2, 0, 0);
    debugExtensionsBit <= 1'b0;
    longMode64 <= 1'b1;
    // refused writes carry low halves that would show if stored
    mv(1, 7, 64'h1_0f10_0400, 1, 0, 0);
    mv(1, 6, 64'h8000_0000_ffff_fff1, 1, 0, 0);
    mv(0, 7, 0, 0, {32'h0, mCtrl}, ALL);
    // bp1 global write-only 1 byte, bp2 local read/write 4 bytes
    mv(1, 7, 64'h0f10_d818, 0, 0, 0);
    mCtrl = 32'h0f10_0418;
    mv(0, 7, 0, 0, {32'h0, mCtrl}, ALL);
    mBp[1] = rnd64();
    mBp[2] = rnd64() & ~64'h3;
    mv(1, 1, mBp[1], 0, 0, 0);
    mv(1, 2, mBp[2], 0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      ev(mBp[1], k[1:0], 4'h1, k == 1);
      if (k == 1) mHit = 4'b0010;
      mv(0, 6, 0, 0, st(), ALL);
    end
    ev(mBp[2] + 64'h4, 2'h3, 4'h1, 1'b0);
    ev(mBp[2] + 64'h3, 2'h3, 4'h1, 1'b1);
    mHit = 4'b0100;
    mv(0, 6, 0, 0, st(), ALL);
    ev(0, 0, 4'h2, 1'b1);
    mSt[1] = 1'b1;
    mv(0, 6, 0, 0, st(), NOHIT);
    ev(0, 0, 4'h4, 1'b0);
    mCtrl = mCtrl & ~32'h55;
    mv(0, 7, 0, 0, {32'h0, mCtrl}, ALL);
    ev(0, 0, 4'hc, 1'b1);
    mSt[2] = 1'b1;
    mv(0, 6, 0, 0, st(), NOHIT);
    // software clears the sticky bits by writing them as zero
    mv(1, 6, 64'hffff_0ff0, 0, 0, 0);
    mSt = 3'h0;
    mHit = 4'h0;
    mv(0, 6, 0, 0, st(), ALL);
    mCtrl = mCtrl | 32'h2000;
    mv(1, 7, {32'h0, mCtrl}, 0, 0, 0);
    mv(0, 0, 0, 3, 0, 0);
    mv(1, 1, rnd64(), 3, 0, 0);
    @(posedge ref_clk);
    handlerEntry <= 1'b1;
    @(posedge ref_clk);
    handlerEntry <= 1'b0;
    mCtrl = mCtrl & ~32'h2000;
    mSt[0] = 1'b1;
    mv(0, 6, 0, 0, st(), NOHIT);
    mv(0, 7, 0, 0, {32'h0, mCtrl}, ALL);
    mv(0, 1, 0, 0, mBp[1], ALL);
    // bp0 I/O 8 bytes, bp2 write 2 bytes, bp3 execute 1 byte, all global
    mBp[0] = rnd64() & ~64'h7;
    mBp[3] = rnd64();
    mv(1, 0, mBp[0], 0, 0, 0);
    mv(1, 3, mBp[3], 0, 0, 0);
    mv(1, 7, 64'h050a_04a2, 0, 0, 0);
    ev(mBp[0] + 64'h7, 2'h2, 4'h1, 1'b0);
    debugExtensionsBit <= 1'b1;
    ev(mBp[0] + 64'h7, 2'h2, 4'h1, 1'b1);
    ev(mBp[2] + 64'h2, 2'h1, 4'h1, 1'b0);
    ev(mBp[2] + 64'h1, 2'h1, 4'h1, 1'b1);
    ev(mBp[3], 2'h0, 4'h1, 1'b1);
    mHit = 4'b1000;
    mv(0, 6, 0, 0, st(), ALL);
    // 8-byte range collapses to one byte outside long mode
    longMode64 <= 1'b0;
    ev(mBp[0] + 64'h7, 2'h2, 4'h1, 1'b0);
    ev(mBp[0], 2'h2, 4'h1, 1'b1);
    wrap_up();
  end
endmodule
